/* File: apb_reg_port.sv */
// APB slave with zero wait states, feeding the register bank.
// Assumes a 32-bit APB master on pclk; data sits in bits 7:0.
`default_nettype none

module apb_reg_port (
    input  wire logic        pclk,
    input  wire logic        presetn,
    input  wire logic [11:0] paddr,
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [31:0] pwdata,
    output var  logic [31:0] prdata,
    output var  logic        pready,
    output var  logic        pslverr,
    reg_access_if.port       bus
);

    logic setup;
    logic done;
    logic aligned;

    // ****************************************************************
    // Decode
    // ****************************************************************
    assign setup     = psel & ~penable;
    assign done      = psel & penable & pready;
    assign aligned   = (paddr[1:0] == 2'h0) & (paddr[11:10] == 2'h0);
    assign bus.index = paddr[9:2];
    assign bus.wdata = pwdata[7:0];
    assign bus.rd_stb = done & ~pwrite & ~pslverr;
    assign bus.wr_stb = done & pwrite & ~pslverr;

    // Answer is prepared in the setup cycle
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pready  <= 1'b0;
            pslverr <= 1'b0;
            prdata  <= 32'h0000_0000;
        end else begin
            pready  <= setup;
            if (setup) begin
                pslverr <= ~(aligned & bus.hit);
                prdata  <= (aligned & bus.hit & ~pwrite) ?
                           {24'h00_0000, bus.rdata} : 32'h0000_0000;
            end
        end
    end

endmodule // apb_reg_port

`default_nettype wire

/* File: host_apb.sv */
// Host processor model: APB master reading the status registers.
// Assumes pclk from the bench; one transfer at a time.
`default_nettype none
module host_apb (
    input  wire logic        pclk,
    output var  logic [11:0] paddr,
    output var  logic        psel,
    output var  logic        penable,
    output var  logic        pwrite,
    output var  logic [31:0] pwdata,
    input  wire logic [31:0] prdata,
    input  wire logic        pready,
    input  wire logic        pslverr
);
    timeunit 1ns;
    timeprecision 1ps;
    // Idle bus at time zero
    initial begin
        {paddr, psel, penable, pwrite, pwdata} = '0;
    end
    // Setup, then access held until pready; data taken at that edge
    task automatic xfer(input logic [11:0] a, input logic w,
                        input logic [31:0] d, output logic [31:0] q,
                        output logic e);
        @(posedge pclk);
        paddr   <= a;
        pwrite  <= w;
        pwdata  <= d;
        psel    <= 1'b1;
        @(posedge pclk);
        penable <= 1'b1;
        do @(posedge pclk); while (pready !== 1'b1);
        q = prdata;
        e = pslverr;
        psel    <= 1'b0;
        penable <= 1'b0;
    endtask
endmodule // host_apb
`default_nettype wire

/* File: reg_access_if.sv */
// Carrier between the APB slave and the register bank.
// Assumes both ends run on the same clock.
`default_nettype none

interface reg_access_if;
    logic [7:0] index;   // Word index of the current request
    logic       hit;     // Index maps to a register
    logic [7:0] rdata;   // Read value at index
    logic       rd_stb;  // Read completes this cycle
    logic       wr_stb;  // Write completes this cycle
    logic [7:0] wdata;   // Write data, low byte

    modport port (output index, rd_stb, wr_stb, wdata,
                  input  hit, rdata);
    modport bank (input  index, rd_stb, wr_stb, wdata,
                  output hit, rdata);
endinterface

`default_nettype wire

/* File: seq_status_asserts.sv */
// Port assertions for the sequencer status register bank.
// Assumes binding into seq_status_regs on one pclk domain.
`default_nettype none
module seq_status_asserts (
    input wire logic        pclk,
    input wire logic        presetn,
    input wire logic [11:0] paddr,
    input wire logic        psel,
    input wire logic        penable,
    input wire logic        pwrite,
    input wire logic [31:0] pwdata,
    input wire logic [31:0] prdata,
    input wire logic        pready,
    input wire logic        pslverr,
    input wire logic        interrupt_out_n,
    input wire logic [11:0] pin_sense_level,
    input wire logic [3:0]  pin_slots_nonzero,
    input wire logic [3:0]  alt_function_active,
    input wire logic [7:0]  vendor_fault_set,
    input wire logic        vendor_fault_summary
);
    timeunit 1ns;
    timeprecision 1ps;
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);
    // Read data shape
    AST_UPPER_ZERO: assert property (
        pready |-> prdata[31:8] == 24'h0) else $error("upper bits set");
    AST_PHASE_VALID: assert property (
        pready && !pwrite && paddr == 12'h04C |-> prdata[1:0] != 2'h2)
        else $error("phase code 10 reported");
    // Levels follow the pins when steady
    AST_IRQ_LEVEL: assert property (
        pready && !pwrite && paddr == 12'h04C &&
        $past(interrupt_out_n) == $past(interrupt_out_n, 2)
        |-> prdata[5] == $past(interrupt_out_n)) else $error("irq level");
    AST_SENSE_LEVEL: assert property (
        pready && !pwrite && paddr == 12'h05C &&
        $past(pin_sense_level) == $past(pin_sense_level, 2)
        |-> prdata[7:0] == $past(pin_sense_level[7:0]))
        else $error("sense level");
    // Alternate use locked by slots
    AST_ALT_LOCK: assert property (
        (alt_function_active & $past(pin_slots_nonzero)) == 4'h0)
        else $error("alternate use on locked pin");
    // Vendor flags and summary; unmapped access refused
    AST_SUM_SET: assert property (
        vendor_fault_set != 8'h00 |-> ##[1:2] vendor_fault_summary)
        else $error("summary missed a fault");
    AST_SUM_KEEP: assert property (
        pready && pwrite && paddr == 12'h048 && pwdata[7:0] == 8'h00 &&
        vendor_fault_summary |-> ##2 vendor_fault_summary)
        else $error("zero write cleared a flag");
    AST_UNMAPPED: assert property (
        psel && !penable && paddr == 12'h044 |=> pready && pslverr)
        else $error("unmapped access not refused");
endmodule // seq_status_asserts
bind seq_status_regs seq_status_asserts chk_u (.*);
`default_nettype wire

/* File: seq_status_pkg.sv */
// Constants shared by the sequencer status register bank.
// Assumes one clock domain and a 32-bit APB register port.
`default_nettype none

package seq_status_pkg;

    // ********************************
    // Register indices (byte address is four times the index)
    // ********************************
    localparam logic [7:0] IDX_VENDOR_FAULT   = 8'h12;
    localparam logic [7:0] IDX_CONTROL_PIN    = 8'h13;
    localparam logic [7:0] IDX_DRIVE_UPPER    = 8'h14;
    localparam logic [7:0] IDX_DRIVE_LOWER    = 8'h15;
    localparam logic [7:0] IDX_SENSE_UPPER    = 8'h16;
    localparam logic [7:0] IDX_SENSE_LOWER    = 8'h17;
    localparam logic [7:0] IDX_WATCHDOG       = 8'h18;
    localparam logic [7:0] IDX_SELF_TEST      = 8'h19;
    localparam logic [7:0] IDX_LAST_CAUSE     = 8'h1A;
    localparam logic [7:0] IDX_ALT_ENABLE     = 8'h20;

    // ********************************
    // Field positions
    // ********************************
    localparam int INTERRUPT_PIN_LEVEL  = 5;
    localparam int RESET_PIN_LEVEL      = 4;
    localparam int SLEEP_INPUT_LEVEL    = 3;
    localparam int RUN_INPUT_LEVEL      = 2;
    localparam int WD_WINDOW_OPEN       = 3;
    localparam int WD_EARLY_SERVICE     = 1;
    localparam int WD_TIMEOUT           = 0;
    localparam int SELF_TEST_DONE       = 6;
    localparam int SINGLE_BIT_CORRECTED = 5;
    localparam int CAUSE_EXT_RESET      = 7;
    localparam int CAUSE_WD_RESET       = 6;
    localparam int CAUSE_EMERGENCY      = 4;
    localparam int CAUSE_RUN_LOW        = 3;
    localparam int CAUSE_WD_POWEROFF    = 2;

    // ********************************
    // Reset values and codes
    // ********************************
    localparam logic [7:0] REG_RESET      = 8'h00;
    localparam logic [1:0] PHASE_INVALID  = 2'h2;
    localparam logic [1:0] CODE_NONE      = 2'h0;
    localparam int         PIN_COUNT      = 12;
    localparam int         ALT_PINS       = 4;

endpackage

`default_nettype wire

/* File: seq_status_regs.sv */
// Status register bank of a multichannel power sequencer.
// Assumes pclk at 50 MHz, presetn as power-on reset, APB master.
// How it works
// - Control bit 5 reads 0 while interrupt output pulled low.
// - Control bit 4 reads 0 while reset output held low.
// - Control bit 3 shows sleep request input level.
// - Control bit 2 shows run request input level.
// - Phase field: 00 shutdown, 01 sleep, 11 active; 10 never shown.
// - Drive registers show per-pin driven level, upper 12..9, lower 8..1.
// - Sense registers show per-pin sampled level, same layout.
// - Watchdog bit 3 is 1 while service window open.
// - Watchdog bit 1 sets on early service, clears on read.
// - Watchdog bit 0 sets on timeout, clears on read.
// - Test bit 6 is 1 once self-test has completed.
// - Test bit 5 sets when configuration load corrected one bit.
// - Test bits 3..0 fail flags: volatile, nonvolatile, logic, analog.
// - Reset cause kept while any supply present; only power-on clears.
// - Each reset or shutdown event overwrites the cause register.
// - Cause bit 7 marks external reset input as origin.
// - Cause bit 6 marks watchdog reset as origin.
// - Cause bit 3 marks run input low, bit 4 emergency power-down.
// - Cause bit 2 marks watchdog shutdown; field holds its mode.
// - Nonzero software shutdown code copied into cause bits 1:0 unless cause bit 2 is set.
// - Alternate enable bits 3..0 serve pins 12..9.
// - Alternate use honoured only when pin's sequencing slots are zero.
// - Vendor fault bits clear only by writing 1 to a set bit.
// - Vendor summary bit is OR of all vendor fault bits.
//
// Our own choice: the APB interface to the registers.
`default_nettype none

module seq_status_regs (
    input  wire logic        pclk,
    input  wire logic        presetn,
    // APB port
    input  wire logic [11:0] paddr,
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [31:0] pwdata,
    output var  logic [31:0] prdata,
    output var  logic        pready,
    output var  logic        pslverr,
    // Pin and sequencer state
    input  wire logic        interrupt_out_n,
    input  wire logic        reset_out_n,
    input  wire logic        sleep_request_n,
    input  wire logic        run_request_input,
    input  wire logic [1:0]  sequencer_phase,
    input  wire logic [11:0] pin_drive_level,
    input  wire logic [11:0] pin_sense_level,
    // Watchdog
    input  wire logic        watchdog_window_open,
    input  wire logic        watchdog_early_service,
    input  wire logic        watchdog_timeout,
    // Self-test and configuration load
    input  wire logic        self_test_done,
    input  wire logic        single_bit_corrected,
    input  wire logic        volatile_mem_test_fail,
    input  wire logic        nonvolatile_mem_test_fail,
    input  wire logic        logic_test_fail,
    input  wire logic        analog_test_fail,
    // Reset and shutdown event with its cause
    input  wire logic        reset_event,
    input  wire logic        external_reset_input,
    input  wire logic        watchdog_reset_cause,
    input  wire logic        emergency_powerdown_input,
    input  wire logic        run_low_cause,
    input  wire logic        watchdog_poweroff_cause,
    input  wire logic [1:0]  forced_poweroff_code,
    input  wire logic [1:0]  watchdog_poweroff_mode,
    // Alternate function setup
    input  wire logic        nvm_load_strobe,
    input  wire logic [3:0]  nvm_alt_enable,
    input  wire logic [3:0]  pin_slots_nonzero,
    output var  logic [3:0]  alt_function_active,
    // Vendor faults
    input  wire logic [7:0]  vendor_fault_set,
    output var  logic        vendor_fault_summary
);

    reg_access_if bus ();

    // ********************************
    // Stored state
    // ********************************
    logic [7:0]  control_pin_state_ff;
    logic [11:0] drive_level_ff;
    logic [11:0] sense_level_ff;
    logic        window_open_ff;
    logic [7:0]  self_test_result_ff;
    logic [7:0]  last_reset_cause_ff;
    logic [7:0]  nxt_last_reset_cause;
    logic [3:0]  alt_enable_ff;
    logic [1:0]  phase_ff;
    logic [1:0]  wd_flags;
    logic [1:0]  wd_set;
    logic [1:0]  wd_clr;
    logic [7:0]  vendor_flags;
    logic [7:0]  vendor_clr;
    logic [7:0]  watchdog_state;
    logic [7:0]  control_pin_view;

    // ********************************
    // APB slave
    // ********************************
    apb_reg_port u_port (
        .pclk    (pclk),
        .presetn (presetn),
        .paddr   (paddr),
        .psel    (psel),
        .penable (penable),
        .pwrite  (pwrite),
        .pwdata  (pwdata),
        .prdata  (prdata),
        .pready  (pready),
        .pslverr (pslverr),
        .bus     (bus.port)
    );

    // ********************************
    // Control pin status
    // ********************************

    // Sample pin levels each cycle
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            control_pin_state_ff <= seq_status_pkg::REG_RESET;
        end else begin
            control_pin_state_ff <= 8'h00;
            control_pin_state_ff[seq_status_pkg::INTERRUPT_PIN_LEVEL]
                <= interrupt_out_n;
            control_pin_state_ff[seq_status_pkg::RESET_PIN_LEVEL]
                <= reset_out_n;
            control_pin_state_ff[seq_status_pkg::SLEEP_INPUT_LEVEL]
                <= sleep_request_n;
            control_pin_state_ff[seq_status_pkg::RUN_INPUT_LEVEL]
                <= run_request_input;
        end
    end

    // Phase holds its last legal code
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            phase_ff <= 2'h0;
        end else if (sequencer_phase != seq_status_pkg::PHASE_INVALID) begin
            phase_ff <= sequencer_phase;
        end
    end

    // Phase joins the pin bits
    assign control_pin_view = {control_pin_state_ff[7:2], phase_ff};

    // ********************************
    // Enable pin drive and sense levels
    // ********************************

    // Per-pin copies of drive and sense levels
    for (genvar p = 0; p < seq_status_pkg::PIN_COUNT; p++) begin : g_pin
        always_ff @(posedge pclk or negedge presetn) begin
            if (!presetn) begin
                drive_level_ff[p] <= 1'b0;
                sense_level_ff[p] <= 1'b0;
            end else begin
                drive_level_ff[p] <= pin_drive_level[p];
                sense_level_ff[p] <= pin_sense_level[p];
            end
        end
    end

    // ********************************
    // Watchdog status
    // ********************************

    // Window level
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            window_open_ff <= 1'b0;
        end else begin
            window_open_ff <= watchdog_window_open;
        end
    end

    // Read clears only flags it reported; a late set survives
    assign wd_set = {watchdog_early_service, watchdog_timeout};
    assign wd_clr = (bus.rd_stb && bus.index == seq_status_pkg::IDX_WATCHDOG)
                    ? prdata[1:0] : 2'h0;

    sticky_flags #(
        .WIDTH (2)
    ) u_wd_flags (
        .clk   (pclk),
        .rst_n (presetn),
        .set   (wd_set),
        .clr   (wd_clr),
        .flags (wd_flags)
    );

    // Watchdog word
    always_comb begin
        watchdog_state = 8'h00;
        watchdog_state[seq_status_pkg::WD_WINDOW_OPEN]   = window_open_ff;
        watchdog_state[seq_status_pkg::WD_EARLY_SERVICE] = wd_flags[1];
        watchdog_state[seq_status_pkg::WD_TIMEOUT]       = wd_flags[0];
    end

    // ********************************
    // Self-test result
    // ********************************

    // Sample test status levels
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            self_test_result_ff <= seq_status_pkg::REG_RESET;
        end else begin
            self_test_result_ff <= 8'h00;
            self_test_result_ff[seq_status_pkg::SELF_TEST_DONE]
                <= self_test_done;
            self_test_result_ff[seq_status_pkg::SINGLE_BIT_CORRECTED]
                <= single_bit_corrected;
            self_test_result_ff[3:0]
                <= {volatile_mem_test_fail,
                    nonvolatile_mem_test_fail,
                    logic_test_fail,
                    analog_test_fail};
        end
    end

    // ********************************
    // Last reset cause
    // ********************************

    // Cause word of the event now reported
    always_comb begin
        nxt_last_reset_cause = 8'h00;
        nxt_last_reset_cause[seq_status_pkg::CAUSE_EXT_RESET]
            = external_reset_input;
        nxt_last_reset_cause[seq_status_pkg::CAUSE_WD_RESET]
            = watchdog_reset_cause;
        nxt_last_reset_cause[seq_status_pkg::CAUSE_EMERGENCY]
            = emergency_powerdown_input;
        nxt_last_reset_cause[seq_status_pkg::CAUSE_RUN_LOW]
            = run_low_cause;
        nxt_last_reset_cause[seq_status_pkg::CAUSE_WD_POWEROFF]
            = watchdog_poweroff_cause;
        if (watchdog_poweroff_cause) begin
            nxt_last_reset_cause[1:0] = watchdog_poweroff_mode;
        end else if (forced_poweroff_code != seq_status_pkg::CODE_NONE) begin
            nxt_last_reset_cause[1:0] = forced_poweroff_code;
        end
    end

    // Only power-on clears; each event overwrites
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            last_reset_cause_ff <= seq_status_pkg::REG_RESET;
        end else if (reset_event) begin
            last_reset_cause_ff <= nxt_last_reset_cause;
        end
    end

    // ********************************
    // Alternate function enable
    // ********************************

    // Loaded from configuration, read-only to software
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            alt_enable_ff <= 4'h0;
        end else if (nvm_load_strobe) begin
            alt_enable_ff <= nvm_alt_enable;
        end
    end

    // Pins with sequencing slots stay on sequencing duty
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            alt_function_active <= 4'h0;
        end else begin
            alt_function_active <= alt_enable_ff
                                   & ~pin_slots_nonzero;
        end
    end

    // ********************************
    // Vendor fault flags
    // ********************************

    // Write 1 clears a set bit; zeros do nothing
    assign vendor_clr = (bus.wr_stb &&
                         bus.index == seq_status_pkg::IDX_VENDOR_FAULT) ?
                        bus.wdata : 8'h00;

    sticky_flags #(
        .WIDTH (8)
    ) u_vendor_flags (
        .clk   (pclk),
        .rst_n (presetn),
        .set   (vendor_fault_set),
        .clr   (vendor_clr),
        .flags (vendor_flags)
    );

    // Summary of all vendor faults
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            vendor_fault_summary <= 1'b0;
        end else begin
            vendor_fault_summary <= |vendor_flags;
        end
    end

    // ********************************
    // Read multiplexer
    // ********************************

    // Word at the requested index; reserved bits are zero
    always_comb begin
        bus.hit   = 1'b1;
        bus.rdata = 8'h00;
        unique case (bus.index)
            seq_status_pkg::IDX_VENDOR_FAULT: begin
                bus.rdata = vendor_flags;
            end
            seq_status_pkg::IDX_CONTROL_PIN: begin
                bus.rdata = control_pin_view;
            end
            seq_status_pkg::IDX_DRIVE_UPPER: begin
                bus.rdata = {4'h0, drive_level_ff[11:8]};
            end
            seq_status_pkg::IDX_DRIVE_LOWER: begin
                bus.rdata = drive_level_ff[7:0];
            end
            seq_status_pkg::IDX_SENSE_UPPER: begin
                bus.rdata = {4'h0, sense_level_ff[11:8]};
            end
            seq_status_pkg::IDX_SENSE_LOWER: begin
                bus.rdata = sense_level_ff[7:0];
            end
            seq_status_pkg::IDX_WATCHDOG: begin
                bus.rdata = watchdog_state;
            end
            seq_status_pkg::IDX_SELF_TEST: begin
                bus.rdata = self_test_result_ff;
            end
            seq_status_pkg::IDX_LAST_CAUSE: begin
                bus.rdata = last_reset_cause_ff;
            end
            seq_status_pkg::IDX_ALT_ENABLE: begin
                bus.rdata = {4'h0, alt_enable_ff};
            end
            default: begin
                bus.hit = 1'b0;
            end
        endcase
    end

endmodule // seq_status_regs

`default_nettype wire

/* File: sticky_flags.sv */
// Bank of sticky event flags; a set in the clearing cycle wins.
// Assumes set and clear are single-cycle pulses from the same clock.
`default_nettype none

module sticky_flags #(
    parameter int WIDTH = 8
) (
    input  wire logic             clk,
    input  wire logic             rst_n,
    input  wire logic [WIDTH-1:0] set,
    input  wire logic [WIDTH-1:0] clr,
    output var  logic [WIDTH-1:0] flags
);

    // One flag per bit, set has priority over clear
    for (genvar i = 0; i < WIDTH; i++) begin : g_flag
        always_ff @(posedge clk or negedge rst_n) begin
            if (!rst_n) begin
                flags[i] <= 1'b0;
            end else begin
                flags[i] <= set[i] | (flags[i] & ~clr[i]);
            end
        end
    end

endmodule // sticky_flags

`default_nettype wire

/* File: tb.sv */
// Self-checking bench for the sequencer status register bank.
// Assumes host_apb as bus master and the bound checker.
`default_nettype none
module tb;
    timeunit 1ns;
    timeprecision 1ps;
    logic        pclk, presetn, psel, penable, pwrite, pready, pslverr;
    logic [11:0] paddr, pin_drive_level, pin_sense_level;
    logic [31:0] pwdata, prdata;
    logic [1:0]  sequencer_phase, forced_poweroff_code;
    logic [1:0]  watchdog_poweroff_mode;
    logic        interrupt_out_n, reset_out_n, sleep_request_n;
    logic        run_request_input, watchdog_window_open, watchdog_timeout;
    logic        watchdog_early_service, self_test_done, single_bit_corrected;
    logic        volatile_mem_test_fail, nonvolatile_mem_test_fail;
    logic        logic_test_fail, analog_test_fail, reset_event;
    logic        external_reset_input, watchdog_reset_cause, run_low_cause;
    logic        emergency_powerdown_input, watchdog_poweroff_cause;
    logic        nvm_load_strobe, vendor_fault_summary;
    logic [3:0]  nvm_alt_enable, pin_slots_nonzero, alt_function_active;
    logic [7:0]  vendor_fault_set;
    int          err_count = 0;
    int          n_tests = 0;

    seq_status_regs dut_u (.*);
    host_apb host_u (.*);

    // Clock at 50 MHz
    initial begin
        pclk = 1'b0;
        forever #10 pclk = ~pclk;
    end

    task automatic chk_data(input logic [31:0] got, input logic [31:0] exp);
        n_tests++;
        if (got !== exp) begin
            err_count++;
            $display("BAD %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic rd(input logic [11:0] a, input logic [7:0] x,
                      input logic err);
        logic [31:0] q;
        logic        e;
        host_u.xfer(a, 1'b0, 32'h0, q, e);
        chk_data(q, {24'h0, x});
        chk_data({31'h0, e}, {31'h0, err});
    endtask
    task automatic wr(input logic [11:0] a, input logic [7:0] d);
        logic [31:0] q;
        logic        e;
        host_u.xfer(a, 1'b1, {24'h0, d}, q, e);
        chk_data({31'h0, e}, 32'h0);
    endtask
    task automatic tdone(input string s);
        $display("test %s done", s);
    endtask
    task automatic end_sim;
        $display("comparisons %0d mismatches %0d", n_tests, err_count);
        if (err_count == 0 && n_tests > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask

    // Hang guard
    initial begin
        repeat (5000) @(posedge pclk);
        err_count++;
        end_sim();
    end

    // Test sequence
    logic [11:0] adr [10] = '{12'h048, 12'h04C, 12'h050, 12'h054,
        12'h058, 12'h05C, 12'h060, 12'h064, 12'h068, 12'h080};
    logic [3:0]  pat [3] = '{4'hA, 4'h5, 4'hF};
    logic [1:0]  ph [3] = '{2'h0, 2'h1, 2'h3};
    logic [8:0]  cause [6] = '{9'h100, 9'h080, 9'h040, 9'h020,
        9'h016, 9'h00C};
    initial begin
        logic [8:0]  c;
        {interrupt_out_n, reset_out_n, sleep_request_n, run_request_input,
         watchdog_window_open, watchdog_early_service, watchdog_timeout,
         self_test_done, single_bit_corrected, volatile_mem_test_fail,
         nonvolatile_mem_test_fail, logic_test_fail, analog_test_fail,
         reset_event, external_reset_input, watchdog_reset_cause,
         emergency_powerdown_input, run_low_cause, watchdog_poweroff_cause,
         nvm_load_strobe, sequencer_phase, forced_poweroff_code,
         watchdog_poweroff_mode, pin_drive_level, pin_sense_level,
         nvm_alt_enable, pin_slots_nonzero, vendor_fault_set} = '0;
        presetn = 1'b0;
        repeat (6) @(posedge pclk);
        presetn <= 1'b1;
        foreach (adr[i]) rd(adr[i], 8'h00, 1'b0);
        rd(12'h044, 8'h00, 1'b1);
        rd(12'h04D, 8'h00, 1'b1);
        tdone("reset");
        foreach (pat[i]) begin
            {interrupt_out_n, reset_out_n, sleep_request_n,
             run_request_input} <= pat[i];
            sequencer_phase <= ph[i];
            rd(12'h04C, {2'h0, pat[i], ph[i]},
               1'b0);
        end
        sequencer_phase <= 2'h2;
        rd(12'h04C, 8'h3F, 1'b0);
        tdone("control");
        pin_drive_level <= 12'hA5C;
        pin_sense_level <= 12'h3B1;
        rd(12'h050, 8'h0A, 1'b0);
        rd(12'h054, 8'h5C, 1'b0);
        rd(12'h058, 8'h03, 1'b0);
        rd(12'h05C, 8'hB1, 1'b0);
        tdone("pins");
        watchdog_window_open <= 1'b1;
        watchdog_early_service <= 1'b1;
        @(posedge pclk);
        watchdog_early_service <= 1'b0;
        rd(12'h060, 8'h0A, 1'b0);
        watchdog_timeout <= 1'b1;
        @(posedge pclk);
        {watchdog_timeout, watchdog_window_open} <= 2'b00;
        rd(12'h060, 8'h01, 1'b0);
        rd(12'h060, 8'h00, 1'b0);
        tdone("watchdog");
        {self_test_done, single_bit_corrected, volatile_mem_test_fail,
         nonvolatile_mem_test_fail, logic_test_fail,
         analog_test_fail} <= 6'b111010;
        rd(12'h064, 8'h6A, 1'b0);
        tdone("selftest");
        foreach (cause[i]) begin
            {external_reset_input, watchdog_reset_cause,
             emergency_powerdown_input, run_low_cause,
             watchdog_poweroff_cause, forced_poweroff_code,
             watchdog_poweroff_mode} <= cause[i];
            reset_event <= 1'b1;
            @(posedge pclk);
            reset_event <= 1'b0;
            c = cause[i];
            rd(12'h068, {c[8:7], 1'b0, c[6:4], c[4] ? c[1:0] : c[3:2]},
               1'b0);
        end
        wr(12'h068, 8'hFF);
        rd(12'h068, 8'h03, 1'b0);
        tdone("cause");
        nvm_alt_enable <= 4'hF;
        pin_slots_nonzero <= 4'h5;
        nvm_load_strobe <= 1'b1;
        @(posedge pclk);
        nvm_load_strobe <= 1'b0;
        rd(12'h080, 8'h0F, 1'b0);
        chk_data({28'h0, alt_function_active}, 32'hA);
        tdone("alternate");
        vendor_fault_set <= 8'h05;
        @(posedge pclk);
        vendor_fault_set <= 8'h00;
        rd(12'h048, 8'h05, 1'b0);
        wr(12'h048, 8'h06);
        wr(12'h048, 8'h00);
        rd(12'h048, 8'h01, 1'b0);
        chk_data({31'h0, vendor_fault_summary}, 32'h1);
        wr(12'h048, 8'h01);
        rd(12'h048, 8'h00, 1'b0);
        chk_data({31'h0, vendor_fault_summary}, 32'h0);
        tdone("vendor");
        end_sim();
    end
endmodule // tb
`default_nettype wire
